// ==== rtl/codec_reg_pkg.sv ====
// Register map, field layout and link frame constants for the codec access block
package codec_reg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (low address bits)
    // ------------------------------------------------------------
    localparam int ADDR_DEC_W = 16;
    localparam logic [15:0] OFF_CODEC_COMMAND = 16'hf708;
    localparam logic [15:0] OFF_LINK_INTERRUPT_STATUS = 16'hf710;
    localparam logic [15:0] OFF_MASKED_INTERRUPT_STATUS = 16'hf714;
    localparam logic [15:0] OFF_INTERRUPT_ENABLE_SET = 16'hf718;
    localparam logic [15:0] OFF_INTERRUPT_ENABLE_CLEAR = 16'hf71c;

    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int CMD_DIR_BIT = 31;
    localparam int CMD_SEL_LO = 24;
    localparam int CMD_SEL_W = 2;
    localparam int CMD_ADR_LO = 16;
    localparam int CMD_ADR_W = 7;
    localparam int CMD_DAT_LO = 0;
    localparam int CMD_DAT_W = 16;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STS_W = 16;
    localparam int NUM_ERR = 7;
    localparam int ERR_POS [NUM_ERR] = '{8, 9, 10, 11, 12, 14, 15};
    localparam logic [15:0] STS_ERR_MASK = 16'hdf00;
    localparam int STS_GPIO_BIT = 5;
    localparam int STS_DONE_BIT = 4;
    localparam int STS_RDY1_BIT = 1;
    localparam int STS_RDY0_BIT = 0;
    localparam logic [15:0] STS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // AC-link frame layout
    // ------------------------------------------------------------
    localparam int FRAME_CNT_W = 8;
    localparam logic [7:0] SLOT0_BITS = 8'h10;
    localparam logic [7:0] HDR_LAST = 8'h37;
    localparam logic [7:0] HDR_END = 8'h38;
    localparam logic [7:0] SLOT12_BIT0 = 8'hff;
    localparam int HDR_W = 56;
    localparam int SLOT_W = 20;
    localparam int TAG_VALID = 15;
    localparam int TAG_SLOT1 = 14;
    localparam int TAG_SLOT2 = 13;
    localparam int S1_RW_BIT = 19;
    localparam int S1_ADR_LO = 12;
    localparam int S2_DAT_LO = 4;

    // ------------------------------------------------------------
    // Command engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_PEND = 2'b01,
        CMD_SEND = 2'b10,
        CMD_WAIT = 2'b11
    } cmd_state_e;

endpackage

// ==== rtl/codec_reg_access.sv ====
// AHB-Lite codec command and interrupt status block with AC-link frame engine
`timescale 1ns/1ns

// How it works
// - Command bit 31 set means read a codec register, clear means write.
// - Bits 25:24 carry the codec ID; 0 takes read data from the first input, 1 to 3 from the second.
// - Bits 22:16 take target address; after a read they return the read address.
// - Bits 15:0 carry write data; after a read they hold returned codec data.
// - Status bit 15 sets on modem receive DMA overrun.
// - Status bit 14 sets on modem transmit DMA underrun.
// - Status bit 12 sets on audio receive DMA overrun.
// - Status bit 11 sets on LFE transmit DMA underrun.
// - Status bit 10 sets on center transmit DMA underrun.
// - Status bit 9 sets on surround transmit DMA underrun.
// - Status bit 8 sets on PCM transmit DMA underrun.
// - DMA error flags stay set until software writes one to them.
// - Status bit 5 sets whenever incoming slot 12 bit 0 is one.
// - Writing one clears bit 5 only while slot 12 bit 0 is zero.
// - Status bit 4 sets when the command access has finished.
// - Access complete clears on write one or any command register write.
// - Status bits 1 and 0 mirror codec ready of second and first input.
// - Interrupt output is OR of status ANDed with enable.
// - Enables reset to zero, set by set register, cleared by clear register.
module codec_reg_access (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // DMA error events, one cycle pulses
    input wire logic [codec_reg_pkg::NUM_ERR-1:0] dma_err_event,
    // AC-link
    input wire logic bit_clk,
    input wire logic first_serial_input,
    input wire logic second_serial_input,
    output logic link_sync,
    output logic link_sdata_out,
    // Interrupt request
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic hreadyout_ff;
    logic hresp_ff;
    logic [31:0] hrdata_ff;
    logic wr_act_ff;
    logic [15:0] wr_addr_ff;
    logic addr_phase;
    logic [15:0] dec_addr;
    logic wr_cmd;
    logic wr_sts;
    logic wr_en_set;
    logic wr_en_clr;
    logic [31:0] rd_word;

    logic cmd_dir_ff;
    logic [codec_reg_pkg::CMD_SEL_W-1:0] cmd_sel_ff;
    logic [codec_reg_pkg::CMD_ADR_W-1:0] cmd_adr_ff;
    logic [codec_reg_pkg::CMD_DAT_W-1:0] cmd_dat_ff;
    codec_reg_pkg::cmd_state_e cmd_state_ff;
    codec_reg_pkg::cmd_state_e nxt_cmd_state;
    logic done_evt;

    logic [codec_reg_pkg::STS_W-1:0] sts_ff;
    logic [codec_reg_pkg::STS_W-1:0] en_ff;
    logic [codec_reg_pkg::STS_W-1:0] err_vec;
    logic [codec_reg_pkg::STS_W-1:0] masked;
    logic irq_ff;

    logic bclk_s1_ff;
    logic bclk_s2_ff;
    logic bclk_s3_ff;
    logic first_serial_input_s1_ff;
    logic first_serial_input_s2_ff;
    logic second_serial_input_s1_ff;
    logic second_serial_input_s2_ff;
    logic bclk_rise;
    logic bclk_fall;

    logic [codec_reg_pkg::FRAME_CNT_W-1:0] bit_cnt_ff;
    logic [codec_reg_pkg::FRAME_CNT_W-1:0] rx_idx;
    logic [codec_reg_pkg::HDR_W-1:0] tx_hdr_ff;
    logic link_sync_ff;
    logic link_sdata_ff;
    logic [codec_reg_pkg::HDR_W-1:0] rx0_sh_ff;
    logic [codec_reg_pkg::HDR_W-1:0] rx1_sh_ff;
    logic [codec_reg_pkg::HDR_W-1:0] rx0_full;
    logic [codec_reg_pkg::HDR_W-1:0] rx1_full;
    logic [codec_reg_pkg::HDR_W-1:0] rx_tgt;
    logic [15:0] rx_slot0;
    logic [codec_reg_pkg::SLOT_W-1:0] rx_slot1;
    logic [codec_reg_pkg::SLOT_W-1:0] rx_slot2;
    logic hdr_rx_done;
    logic rd_match;
    logic rdy0_ff;
    logic rdy1_ff;
    logic gpio_in_ff;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign addr_phase = hsel & htrans[1] & hready;
    assign dec_addr = haddr[codec_reg_pkg::ADDR_DEC_W-1:0];
    assign wr_cmd = wr_act_ff & (wr_addr_ff == codec_reg_pkg::OFF_CODEC_COMMAND);
    assign wr_sts = wr_act_ff & (wr_addr_ff == codec_reg_pkg::OFF_LINK_INTERRUPT_STATUS);
    assign wr_en_set = wr_act_ff & (wr_addr_ff == codec_reg_pkg::OFF_INTERRUPT_ENABLE_SET);
    assign wr_en_clr = wr_act_ff & (wr_addr_ff == codec_reg_pkg::OFF_INTERRUPT_ENABLE_CLEAR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_act_ff <= 1'b0;
            wr_addr_ff <= 16'h0000;
        end else begin
            wr_act_ff <= addr_phase & hwrite;
            wr_addr_ff <= addr_phase ? dec_addr : wr_addr_ff;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (dec_addr)
            codec_reg_pkg::OFF_CODEC_COMMAND: begin
                rd_word[codec_reg_pkg::CMD_ADR_LO +: codec_reg_pkg::CMD_ADR_W] = cmd_adr_ff;
                rd_word[codec_reg_pkg::CMD_DAT_LO +: codec_reg_pkg::CMD_DAT_W] = cmd_dat_ff;
            end
            codec_reg_pkg::OFF_LINK_INTERRUPT_STATUS: begin
                rd_word[codec_reg_pkg::STS_W-1:0] = sts_ff;
            end
            codec_reg_pkg::OFF_MASKED_INTERRUPT_STATUS: begin
                rd_word[codec_reg_pkg::STS_W-1:0] = masked;
            end
            codec_reg_pkg::OFF_INTERRUPT_ENABLE_SET: begin
                rd_word[codec_reg_pkg::STS_W-1:0] = en_ff;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            hrdata_ff <= (addr_phase & ~hwrite) ? rd_word : 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;

    // ------------------------------------------------------------
    // Link input synchronisers and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_s1_ff <= 1'b0;
            bclk_s2_ff <= 1'b0;
            bclk_s3_ff <= 1'b0;
            first_serial_input_s1_ff <= 1'b0;
            first_serial_input_s2_ff <= 1'b0;
            second_serial_input_s1_ff <= 1'b0;
            second_serial_input_s2_ff <= 1'b0;
        end else begin
            bclk_s1_ff <= bit_clk;
            bclk_s2_ff <= bclk_s1_ff;
            bclk_s3_ff <= bclk_s2_ff;
            first_serial_input_s1_ff <= first_serial_input;
            first_serial_input_s2_ff <= first_serial_input_s1_ff;
            second_serial_input_s1_ff <= second_serial_input;
            second_serial_input_s2_ff <= second_serial_input_s1_ff;
        end
    end

    assign bclk_rise = bclk_s2_ff & ~bclk_s3_ff;
    assign bclk_fall = ~bclk_s2_ff & bclk_s3_ff;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    // direction bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_dir_ff <= 1'b0;
            cmd_sel_ff <= 2'h0;
            cmd_adr_ff <= 7'h00;
            cmd_dat_ff <= 16'h0000;
        end else if (wr_cmd) begin
            cmd_dir_ff <= hwdata[codec_reg_pkg::CMD_DIR_BIT];
            cmd_sel_ff <= hwdata[codec_reg_pkg::CMD_SEL_LO +: codec_reg_pkg::CMD_SEL_W];
            cmd_adr_ff <= hwdata[codec_reg_pkg::CMD_ADR_LO +: codec_reg_pkg::CMD_ADR_W];
            cmd_dat_ff <= hwdata[codec_reg_pkg::CMD_DAT_LO +: codec_reg_pkg::CMD_DAT_W];
        end else if (rd_match) begin
            cmd_adr_ff <= rx_slot1[codec_reg_pkg::S1_ADR_LO +: codec_reg_pkg::CMD_ADR_W];
            cmd_dat_ff <= rx_slot2[codec_reg_pkg::S2_DAT_LO +: codec_reg_pkg::CMD_DAT_W];
        end
    end

    // ------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------
    // next frame carries command
    always_comb begin
        nxt_cmd_state = cmd_state_ff;
        done_evt = 1'b0;
        case (cmd_state_ff)
            codec_reg_pkg::CMD_IDLE: begin
                if (wr_cmd) begin
                    nxt_cmd_state = codec_reg_pkg::CMD_PEND;
                end
            end
            codec_reg_pkg::CMD_PEND: begin
                if (bclk_rise && bit_cnt_ff == '0) begin
                    nxt_cmd_state = codec_reg_pkg::CMD_SEND;
                end
            end
            codec_reg_pkg::CMD_SEND: begin
                if (bclk_rise && bit_cnt_ff == codec_reg_pkg::HDR_END) begin
                    if (cmd_dir_ff) begin
                        nxt_cmd_state = codec_reg_pkg::CMD_WAIT;
                    end else begin
                        nxt_cmd_state = codec_reg_pkg::CMD_IDLE;
                        done_evt = 1'b1;
                    end
                end
            end
            codec_reg_pkg::CMD_WAIT: begin
                if (rd_match) begin
                    nxt_cmd_state = codec_reg_pkg::CMD_IDLE;
                    done_evt = 1'b1;
                end
            end
            default: begin
                nxt_cmd_state = codec_reg_pkg::CMD_IDLE;
            end
        endcase
        if (wr_cmd) begin
            nxt_cmd_state = codec_reg_pkg::CMD_PEND;
            done_evt = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_state_ff <= codec_reg_pkg::CMD_IDLE;
        end else begin
            cmd_state_ff <= nxt_cmd_state;
        end
    end

    // ------------------------------------------------------------
    // Transmit frame
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_ff <= '0;
            tx_hdr_ff <= '0;
            link_sync_ff <= 1'b0;
            link_sdata_ff <= 1'b0;
        end else if (bclk_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 8'h01;
            link_sync_ff <= bit_cnt_ff < codec_reg_pkg::SLOT0_BITS;
            if (bit_cnt_ff == '0) begin
                tx_hdr_ff <= '0;
                if (cmd_state_ff == codec_reg_pkg::CMD_PEND) begin
                    tx_hdr_ff[codec_reg_pkg::HDR_W-1-(15-codec_reg_pkg::TAG_VALID)] <= 1'b1;
                    tx_hdr_ff[codec_reg_pkg::HDR_W-1-(15-codec_reg_pkg::TAG_SLOT1)] <= 1'b1;
                    tx_hdr_ff[codec_reg_pkg::HDR_W-1-(15-codec_reg_pkg::TAG_SLOT2)] <= ~cmd_dir_ff;
                    tx_hdr_ff[codec_reg_pkg::HDR_W-16 +: codec_reg_pkg::CMD_SEL_W] <= cmd_sel_ff;
                    tx_hdr_ff[codec_reg_pkg::SLOT_W + codec_reg_pkg::S1_RW_BIT] <= cmd_dir_ff;
                    tx_hdr_ff[codec_reg_pkg::SLOT_W + codec_reg_pkg::S1_ADR_LO
                        +: codec_reg_pkg::CMD_ADR_W] <= cmd_adr_ff;
                    tx_hdr_ff[codec_reg_pkg::S2_DAT_LO +: codec_reg_pkg::CMD_DAT_W] <=
                        cmd_dir_ff ? 16'h0000 : cmd_dat_ff;
                end
                link_sdata_ff <= (cmd_state_ff == codec_reg_pkg::CMD_PEND);
            end else if (bit_cnt_ff <= codec_reg_pkg::HDR_LAST) begin
                link_sdata_ff <= tx_hdr_ff[codec_reg_pkg::HDR_W-1-32'(bit_cnt_ff)];
            end else begin
                link_sdata_ff <= 1'b0;
            end
        end
    end

    assign link_sync = link_sync_ff;
    assign link_sdata_out = link_sdata_ff;

    // ------------------------------------------------------------
    // Receive frame
    // ------------------------------------------------------------
    assign rx_idx = bit_cnt_ff - 8'h01;
    assign rx0_full = {rx0_sh_ff[codec_reg_pkg::HDR_W-2:0], first_serial_input_s2_ff};
    assign rx1_full = {rx1_sh_ff[codec_reg_pkg::HDR_W-2:0], second_serial_input_s2_ff};
    assign rx_tgt = (cmd_sel_ff == 2'h0) ? rx0_full : rx1_full;
    assign rx_slot0 = rx_tgt[codec_reg_pkg::HDR_W-1 -: 16];
    assign rx_slot1 = rx_tgt[codec_reg_pkg::SLOT_W +: codec_reg_pkg::SLOT_W];
    assign rx_slot2 = rx_tgt[codec_reg_pkg::SLOT_W-1:0];
    assign hdr_rx_done = bclk_fall & (rx_idx == codec_reg_pkg::HDR_LAST);
    assign rd_match = hdr_rx_done & (cmd_state_ff == codec_reg_pkg::CMD_WAIT)
        & rx_slot0[codec_reg_pkg::TAG_SLOT1]
        & (rx_slot1[codec_reg_pkg::S1_ADR_LO +: codec_reg_pkg::CMD_ADR_W] == cmd_adr_ff);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx0_sh_ff <= '0;
            rx1_sh_ff <= '0;
            rdy0_ff <= 1'b0;
            rdy1_ff <= 1'b0;
            gpio_in_ff <= 1'b0;
        end else if (bclk_fall) begin
            rx0_sh_ff <= rx0_full;
            rx1_sh_ff <= rx1_full;
            if (rx_idx == codec_reg_pkg::HDR_LAST) begin
                rdy0_ff <= rx0_full[codec_reg_pkg::HDR_W-1-(15-codec_reg_pkg::TAG_VALID)];
                rdy1_ff <= rx1_full[codec_reg_pkg::HDR_W-1-(15-codec_reg_pkg::TAG_VALID)];
            end
            if (rx_idx == codec_reg_pkg::SLOT12_BIT0) begin
                gpio_in_ff <= first_serial_input_s2_ff | second_serial_input_s2_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and enable registers
    // ------------------------------------------------------------
    // map DMA error events to status error bits
    always_comb begin
        err_vec = '0;
        for (int i = 0; i < codec_reg_pkg::NUM_ERR; i++) begin
            err_vec[codec_reg_pkg::ERR_POS[i]] = dma_err_event[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_ff <= codec_reg_pkg::STS_RESET;
        end else begin
            sts_ff[15:8] <= (sts_ff[15:8] & ~(wr_sts ? hwdata[15:8] : 8'h00)
                & codec_reg_pkg::STS_ERR_MASK[15:8]) | err_vec[15:8];
            // clear only when slot input low
            sts_ff[codec_reg_pkg::STS_GPIO_BIT] <= gpio_in_ff
                | (sts_ff[codec_reg_pkg::STS_GPIO_BIT]
                & ~(wr_sts & hwdata[codec_reg_pkg::STS_GPIO_BIT]));
            // cleared by write one or command write
            sts_ff[codec_reg_pkg::STS_DONE_BIT] <= done_evt
                | (sts_ff[codec_reg_pkg::STS_DONE_BIT] & ~wr_cmd
                & ~(wr_sts & hwdata[codec_reg_pkg::STS_DONE_BIT]));
            sts_ff[codec_reg_pkg::STS_RDY1_BIT] <= rdy1_ff;
            sts_ff[codec_reg_pkg::STS_RDY0_BIT] <= rdy0_ff;
            sts_ff[7:6] <= 2'h0;
            sts_ff[3:2] <= 2'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ff <= '0;
        end else if (wr_en_set) begin
            en_ff <= en_ff | (hwdata[codec_reg_pkg::STS_W-1:0] & ~16'h20cc);
        end else if (wr_en_clr) begin
            en_ff <= en_ff & ~hwdata[codec_reg_pkg::STS_W-1:0];
        end
    end

    assign masked = sts_ff & en_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |masked;
        end
    end

    assign irq = irq_ff;

endmodule

// ==== dv/codec_reg_checker.sv ====
// Bus-side checker for the codec access block
`timescale 1ns/1ns
module codec_reg_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Events and interrupt
    input wire logic [codec_reg_pkg::NUM_ERR-1:0] dma_err_event,
    input wire logic irq
);
    logic dp_ff, wr_ff, rd, sts_w;
    logic [15:0] a_ff, en_ff, err_ff;
    assign rd = dp_ff && !wr_ff;
    assign sts_w = dp_ff && wr_ff && a_ff == 16'hf710;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {dp_ff, wr_ff, a_ff} <= '0;
        end else if (hready) begin
            dp_ff <= hsel & htrans[1];
            wr_ff <= hwrite;
            a_ff <= haddr[15:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ff <= '0;
        end else if (dp_ff && wr_ff && a_ff == 16'hf718) begin
            en_ff <= en_ff | (hwdata[15:0] & 16'hdf33);
        end else if (dp_ff && wr_ff && a_ff == 16'hf71c) begin
            en_ff <= en_ff & ~hwdata[15:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_ff <= '0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (dma_err_event[i] || (sts_w && hwdata[codec_reg_pkg::ERR_POS[i]])) begin
                    err_ff[codec_reg_pkg::ERR_POS[i]] <= dma_err_event[i];
                end
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_sts_rsvd;
        rd && a_ff == 16'hf710 |-> (hrdata & 32'hffff20cc) == 32'h0;
    endproperty
    a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved bits set");
    property p_cmd_rsvd;
        rd && a_ff == 16'hf708 |-> hrdata[31:23] == 9'h0;
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command upper bits set");
    property p_unmapped;
        rd && !(a_ff inside {16'hf708, 16'hf710, 16'hf714, 16'hf718}) |-> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_read;
        rd && a_ff == 16'hf718 |-> hrdata == {16'h0, $past(en_ff)};
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable readback wrong");
    property p_masked;
        rd && a_ff == 16'hf714 |-> (hrdata & ~{16'h0, $past(en_ff)}) == 32'h0;
    endproperty
    a_masked: assert property (p_masked) else $error("masked bit without enable");
    property p_irq_off;
        en_ff == 16'h0 ##1 en_ff == 16'h0 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with nothing enabled");
    property p_err_flags;
        rd && a_ff == 16'hf710 |-> (hrdata[15:0] & 16'hdf00) == ($past(err_ff) & 16'hdf00);
    endproperty
    a_err_flags: assert property (p_err_flags) else $error("error flags wrong");
    property p_cmd_clr;
        dp_ff && wr_ff && a_ff == 16'hf708 ##2 rd && a_ff == 16'hf710 |-> !hrdata[4];
    endproperty
    a_cmd_clr: assert property (p_cmd_clr) else $error("done kept after command");
    property p_w1c_done;
        sts_w && hwdata[4] ##2 rd && a_ff == 16'hf710 |-> !hrdata[4];
    endproperty
    a_w1c_done: assert property (p_w1c_done) else $error("done kept after clear");
endmodule
bind codec_reg_access codec_reg_checker codec_reg_checker_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .dma_err_event(dma_err_event), .irq(irq));

// ==== dv/codec_link_model.sv ====
// Behavioural codec at the far end of the link
`timescale 1ns/1ns
module codec_link_model (
    // Link pins
    input wire logic bit_clk,
    input wire logic link_sync,
    input wire logic link_sdata_out,
    output logic first_serial_input,
    output logic second_serial_input,
    // Codec state
    input wire logic rdy_first,
    input wire logic rdy_second,
    input wire logic gpio_bit
);
    logic [7:0] pos = 8'h0;
    logic live = 1'h0;
    logic [55:0] hdr = '0;
    logic [255:0] fa = '0;
    logic [255:0] fb = '0;
    initial first_serial_input = 1'h0;
    initial second_serial_input = 1'h0;
    always @(posedge bit_clk) begin
        if (!live && link_sync) begin
            live = 1'h1;
            pos = 8'h1;
        end
        if (live && pos != 8'h0 && pos <= 8'h38) begin
            hdr[56 - pos] = link_sdata_out;
        end
        if (pos == 8'h39) begin
            fa[254] = hdr[54] && hdr[39] && hdr[41:40] == 2'h0;
            fb[254] = hdr[54] && hdr[39] && hdr[41:40] != 2'h0;
            fa[239:200] = {1'h0, hdr[38:32], 12'h0, hdr[38:32], 9'h15a, 4'h0};
            fb[239:200] = fa[239:200];
        end
        fa[255] = rdy_first;
        fb[255] = rdy_second;
        fa[0] = gpio_bit;
        first_serial_input <= live ? fa[8'hff - pos] : 1'h0;
        second_serial_input <= live ? fb[8'hff - pos] : 1'h0;
        if (live) begin
            pos = pos + 8'h1;
        end
    end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the codec access block
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic wr; logic [15:0] a; logic [31:0] d;} row_s;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic bit_clk = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [6:0] dma_err_event = '0;
    logic rdy_first = 1'h1;
    logic rdy_second = 1'h0;
    logic gpio_bit = 1'h0;
    logic hreadyout, hresp, irq, link_sync, link_sdata_out, sd0, sd1;
    logic [31:0] hrdata, rd, want;
    int errors = 0;
    int checks = 0;
    row_s rows [11] = '{'{1'h0, 16'hf710, 32'h0}, '{1'h0, 16'hf718, 32'h0},
        '{1'h1, 16'hf718, 32'hffffffff}, '{1'h0, 16'hf718, 32'h0000df33},
        '{1'h1, 16'hf71c, 32'h0000ff00}, '{1'h0, 16'hf718, 32'h00000033},
        '{1'h1, 16'hf700, 32'hffffffff}, '{1'h0, 16'hf700, 32'h0}, '{1'h0, 16'hf71c, 32'h0},
        '{1'h1, 16'hf71c, 32'hffffffff}, '{1'h0, 16'hf714, 32'h0}};
    always #5 hclk = ~hclk;
    initial begin
        #7;
        forever #40 bit_clk = ~bit_clk;
    end
    codec_reg_access codec_reg_access_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .dma_err_event(dma_err_event), .bit_clk(bit_clk), .first_serial_input(sd0),
        .second_serial_input(sd1), .link_sync(link_sync), .link_sdata_out(link_sdata_out),
        .irq(irq));
    codec_link_model codec_link_model_i (.bit_clk(bit_clk), .link_sync(link_sync),
        .link_sdata_out(link_sdata_out), .first_serial_input(sd0), .second_serial_input(sd1),
        .rdy_first(rdy_first), .rdy_second(rdy_second), .gpio_bit(gpio_bit));
    task automatic check(input logic [31:0] got, input logic [31:0] exp_v);
        checks++;
        if (got !== exp_v) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp_v);
        end
    endtask
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {16'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic sts(input logic [31:0] wd, input logic [31:0] m, input logic [31:0] e);
        xfer(1'h1, 16'hf710, wd);
        xfer(1'h0, 16'hf710, '0);
        check(rd & m, e);
    endtask
    task automatic wait_done();
        rd = '0;
        for (int n = 0; n < 4000 && rd[4] !== 1'h1; n++) begin
            xfer(1'h0, 16'hf710, '0);
        end
        check(rd & 32'h10, 32'h10);
    endtask
    task automatic summarize();
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #600000;
        errors++;
        summarize();
    end
    initial begin
        want = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) check(rd, rows[i].d);
        end
        check({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            dma_err_event[i] <= 1'h1;
            @(posedge hclk);
            dma_err_event <= '0;
            want[codec_reg_pkg::ERR_POS[i]] = 1'h1;
            sts(32'h0, 32'hdf00, want);
        end
        sts(32'h4100, 32'hdf00, 32'h9e00);
        xfer(1'h1, 16'hf718, 32'h8000);
        xfer(1'h0, 16'hf714, '0);
        check(rd, 32'h8000);
        check({31'h0, irq}, 32'h1);
        sts(32'hffff, 32'hdf00, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        xfer(1'h1, 16'hf708, 32'h022a1234);
        wait_done();
        check({3'h0, codec_link_model_i.hdr[55:53], codec_link_model_i.hdr[41:32],
            codec_link_model_i.hdr[19:4]}, 32'h1e2a1234);
        sts(32'h10, 32'h10, 32'h0);
        for (int k = 0; k < 2; k++) begin
            xfer(1'h1, 16'hf708, k ? 32'h81150000 : 32'h807f0000);
            wait_done();
            xfer(1'h0, 16'hf708, '0);
            check(rd, k ? 32'h00152b5a : 32'h007fff5a);
        end
        sts(32'h0, 32'h3, 32'h1);
        rdy_first <= 1'h0;
        rdy_second <= 1'h1;
        gpio_bit <= 1'h1;
        repeat (2600) @(posedge hclk);
        sts(32'h0, 32'h3, 32'h2);
        sts(32'h20, 32'h20, 32'h20);
        gpio_bit <= 1'h0;
        repeat (2600) @(posedge hclk);
        sts(32'h20, 32'h20, 32'h0);
        xfer(1'h1, 16'hf718, 32'h33);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        xfer(1'h0, 16'hf718, '0);
        check(rd, 32'h0);
        summarize();
    end
endmodule
